/* design/shift4_reg.sv */
// 4-bit parallel-access shift register with jk-bar first stage
// assumes inputs synchronous to clk_i; snapshots go out through a buffer
`timescale 1ns/1ps
`default_nettype none
module shift4_reg (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       clear_n_i,
    input  wire logic       shift_load_i,
    input  wire logic       serial_j_i,
    input  wire logic       serial_k_n_i,
    input  wire logic       parallel_in_0,
    input  wire logic       parallel_in_1,
    input  wire logic       parallel_in_2,
    input  wire logic       parallel_in_3,
    output logic            stage_a_out,
    output logic            stage_b_out,
    output logic            stage_c_out,
    output logic            stage_d_out,
    output logic            stage_d_inv_o,
    output logic [4:0]      snap_data_o,
    output logic            snap_valid_o,
    input  wire logic       snap_ready_i,
    output logic            snap_stall_o
);
    // ********************************************************
    // stage update
    // ********************************************************
    logic [3:0] stages_q;
    logic [3:0] stages_d;
    logic       d_inv_q;
    logic       first_d;
    logic       clear_n;

    // clear is folded into the async reset so it overrides the clock
    assign clear_n = reset_n_i && clear_n_i;

    // first stage behaves as jk-bar: j=0,kb=1 hold; 00 low; 11 high; 10 flip
    function automatic logic jk_next(input logic j, input logic kb,
                                     input logic q);
        jk_next = (j & ~q) | (kb & q);
    endfunction : jk_next

    // next state: load ignores j/k entirely
    always_comb begin
        first_d = jk_next(serial_j_i, serial_k_n_i, stages_q[0]);
        if (shift_load_i == shift4_pkg::MODE_LOAD) begin
            stages_d = {parallel_in_3, parallel_in_2,
                        parallel_in_1, parallel_in_0};
        end else begin
            stages_d = {stages_q[2:0], first_d};
        end
    end

    // stages and inverse update on the rising edge, or at once when clear goes low
    always_ff @(posedge clk_i or negedge clear_n) begin
        if (!clear_n) begin
            stages_q <= shift4_pkg::STAGES_RESET;
            d_inv_q  <= 1'b1;
        end else begin
            stages_q <= stages_d;
            d_inv_q  <= ~stages_d[3];
        end
    end

    assign stage_a_out = stages_q[0];
    assign stage_b_out = stages_q[1];
    assign stage_c_out = stages_q[2];
    assign stage_d_out = stages_q[3];
    assign stage_d_inv_o = d_inv_q;

    // ********************************************************
    // snapshot stream
    // ********************************************************
    // each clocked state is offered downstream unless the buffer is full, when it is skipped;
    // the stall flag tells the source, a word is never overwritten
    shift4_pkg::word_type word_in;
    logic [4:0]           buf_data;
    logic                 buf_valid;
    logic                 buf_in_ready;
    logic                 snap_push_q;
    logic [4:0]           snap_word_q;
    logic                 stall_q;
    logic                 buf_out_ready;

    assign word_in.stages = stages_q;
    assign word_in.d_inv = d_inv_q;

    // hold a pending word until the buffer accepts it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            snap_push_q <= 1'b0;
            snap_word_q <= 5'h00;
            stall_q     <= 1'b0;
        end else begin
            if (!snap_push_q || buf_in_ready) begin
                snap_push_q <= 1'b1;
                snap_word_q <= word_in;
            end
            stall_q <= !buf_in_ready;
        end
    end

    skid_buffer #(
        .WIDTH (5),
        .DEPTH (shift4_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .in_data_i   (snap_word_q),
        .in_valid_i  (snap_push_q),
        .in_ready_o  (buf_in_ready),
        .out_data_o  (buf_data),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_out_ready)
    );

    // registered output stage; takes a word when empty or draining
    logic [4:0] out_data_q;
    logic       out_valid_q;
    assign buf_out_ready = !out_valid_q || snap_ready_i;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_data_q  <= 5'h00;
            out_valid_q <= 1'b0;
        end else if (buf_out_ready) begin
            out_data_q  <= buf_data;
            out_valid_q <= buf_valid;
        end
    end

    assign snap_data_o = out_data_q;
    assign snap_valid_o = out_valid_q;
    assign snap_stall_o = stall_q;

    // ********************************************************
    // checks
    // ********************************************************
    // clear is sampled at the edge as well: an edge that still sees clear
    // low leaves the stages cleared even though clear rises right after
    clear_forces_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !clear_n_i |-> (stages_q == 4'h0) && d_inv_q)
        else $error("clear did not force stages");
    load_parallel_a: assert property (
        @(posedge clk_i) disable iff (!clear_n)
        clear_n && !shift_load_i |=> stages_q == $past({parallel_in_3,
        parallel_in_2, parallel_in_1, parallel_in_0}))
        else $error("parallel load mismatch");
    load_inverse_a: assert property (
        @(posedge clk_i) disable iff (!clear_n)
        clear_n && !shift_load_i |=> d_inv_q == !$past(parallel_in_3))
        else $error("load inverse wrong");
    load_ignore_a: assert property (
        @(posedge clk_i) disable iff (!clear_n)
        clear_n && !shift_load_i && !serial_j_i && !serial_k_n_i
        && parallel_in_0 |=> stages_q[0])
        else $error("serial input leaked into load");
    load_block_a: assert property (
        @(posedge clk_i) disable iff (!clear_n)
        clear_n && !shift_load_i && serial_j_i && serial_k_n_i
        && !parallel_in_0 |=> !stages_q[0])
        else $error("serial set leaked into load");
    shift_move_a: assert property (
        @(posedge clk_i) disable iff (!clear_n)
        clear_n && shift_load_i |=> stages_q[3:1] == $past(stages_q[2:0]))
        else $error("shift path wrong");
    shift_inverse_a: assert property (
        @(posedge clk_i) disable iff (!clear_n)
        clear_n && shift_load_i |=> d_inv_q == !$past(stages_q[2]))
        else $error("shift inverse wrong");
    // equal inputs give their level; unequal ones hold (j low) or flip
    jk_first_a: assert property (
        @(posedge clk_i) disable iff (!clear_n)
        clear_n && shift_load_i |=> stages_q[0] == (($past(serial_j_i)
        == $past(serial_k_n_i)) ? $past(serial_j_i)
        : ($past(stages_q[0]) ^ $past(serial_j_i))))
        else $error("first stage jk wrong");
    inverse_track_a: assert property (
        @(posedge clk_i) disable iff (!clear_n)
        ##1 d_inv_q == ~stages_q[3])
        else $error("inverse output wrong");
    hold_steady_a: assert property (
        @(posedge clk_i) disable iff (!clear_n)
        clear_n && shift_load_i && !serial_j_i && serial_k_n_i
        |=> stages_q[0] == $past(stages_q[0]))
        else $error("stage a did not hold");

    // stream checks follow reset only; clear just changes the words
    buf_order_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        snap_valid_o && !snap_ready_i |=> snap_valid_o
        && $stable(snap_data_o))
        else $error("output word dropped under stall");
    pending_hold_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        snap_push_q && !buf_in_ready |=> $stable(snap_word_q))
        else $error("pending word overwritten");
    stall_flag_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        1'b1 |=> snap_stall_o == !$past(buf_in_ready))
        else $error("stall flag wrong");
    word_pair_a: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        snap_valid_o |-> snap_data_o[0] == !snap_data_o[4])
        else $error("output word inconsistent");

    load_c: cover property (@(posedge clk_i) !shift_load_i);
    toggle_c: cover property (@(posedge clk_i)
        shift_load_i && serial_j_i && !serial_k_n_i);
    stall_c: cover property (@(posedge clk_i) snap_stall_o);
    clear_mid_c: cover property (@(posedge clk_i) reset_n_i && !clear_n_i);
    stall_end_c: cover property (@(posedge clk_i)
        snap_stall_o ##1 !snap_stall_o);
endmodule : shift4_reg
`default_nettype wire

/* design/shift4_pkg.sv */
// shared constants and carrier types for the 4-bit parallel-access register
// assumes a single 100 MHz clock domain; no register bus
package shift4_pkg;

    localparam int          STAGE_COUNT = 4;
    localparam logic [3:0]  STAGES_RESET = 4'h0;
    localparam logic        MODE_LOAD = 1'b0;
    localparam logic        MODE_SHIFT = 1'b1;
    localparam int          BUF_DEPTH = 2;

    // one word of register state: stages a..d and the inverted last stage
    typedef struct packed {
        logic [3:0] stages;   // bit 0 = stage a, bit 3 = stage d
        logic       d_inv;
    } word_type;

endpackage : shift4_pkg

/* design/skid_buffer.sv */
// two-entry buffer with valid and ready on both sides
// assumes one clock; the drain side may stall freely
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic             wr_q;
    logic             rd_q;
    logic [1:0]       cnt_q;
    logic             push;
    logic             pop;

    assign push = in_valid_i && (cnt_q != 2'(DEPTH));
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = (cnt_q != 2'(DEPTH));
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = mem_q[rd_q];

    // storage writes; pointers wrap on a depth of two
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end
endmodule : skid_buffer
`default_nettype wire

/* sim/drain_model.sv */
// drain side of the snapshot stream: takes words, stalls on command
// assumes the same clock and reset as the shift register
`timescale 1ns/1ps
`default_nettype none
module drain_model (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic stall_i,
    input  wire logic valid_i,
    output logic      ready_o,
    output var int    taken_o
);
    // ready drops only when the bench asks, so back-pressure is repeatable
    assign ready_o = !stall_i;

    // count of accepted words, used to prove the stream moved at all
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) taken_o <= 0;
        else if (valid_i && ready_o) taken_o <= taken_o + 1;
    end
endmodule : drain_model
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the 4-bit parallel-access shift register
// assumes shift4_pkg, skid_buffer, shift4_reg and drain_model compiled
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk_i        = 1'b0;
    logic       reset_n_i    = 1'b0;
    logic       clear_n_i    = 1'b1;
    logic       shift_load_i = 1'b0;
    logic       j_in         = 1'b0;
    logic       kn_in        = 1'b0;
    logic       stall        = 1'b0;
    logic       saw_stall    = 1'b0;
    logic [3:0] par          = 4'h0;
    logic [3:0] exp_q        = 4'h0;
    logic [3:0] q;
    logic       q_inv;
    logic [4:0] snap;
    logic       snap_valid;
    logic       snap_ready;
    logic       snap_stall;
    int         err_total    = 0;
    int         check_count  = 0;
    int         taken;

    always #5 clk_i = ~clk_i;

    shift4_reg u_shift4_reg (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .clear_n_i(clear_n_i),
        .shift_load_i(shift_load_i), .serial_j_i(j_in),
        .serial_k_n_i(kn_in), .parallel_in_0(par[0]),
        .parallel_in_1(par[1]), .parallel_in_2(par[2]),
        .parallel_in_3(par[3]), .stage_a_out(q[0]), .stage_b_out(q[1]),
        .stage_c_out(q[2]), .stage_d_out(q[3]), .stage_d_inv_o(q_inv),
        .snap_data_o(snap), .snap_valid_o(snap_valid),
        .snap_ready_i(snap_ready), .snap_stall_o(snap_stall));

    drain_model u_drain_model (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .stall_i(stall),
        .valid_i(snap_valid), .ready_o(snap_ready), .taken_o(taken));

    // ***********************************************
    // reference model and comparison
    // ***********************************************
    // next stage state; first stage acts as a jk-bar flip-flop in shift
    function automatic logic [3:0] next_q(logic [3:0] s, logic m,
                                          logic jj, logic kk,
                                          logic [3:0] p);
        logic a;
        a = (jj & ~s[0]) | (kk & s[0]);
        if (m == shift4_pkg::MODE_LOAD) return p;
        return {s[2:0], a};
    endfunction : next_q

    task automatic chk(string name, logic [4:0] expv, logic [4:0] got);
        check_count++;
        if (got !== expv) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, expv, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    // watchdog: the run needs about 410 cycles, allow far more
    initial begin
        #50000;
        err_total++;
        print_verdict();
    end

    // first two steps are a fixed load 1010 then a shift with j=kbar=1
    initial begin
        void'($urandom(51));
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_i);
            clear_n_i    <= (i < 8) || (($urandom % 16) != 0);
            shift_load_i <= (i == 0) ? 1'b0 : (i == 1) ? 1'b1 : 1'($urandom);
            j_in         <= (i == 1) ? 1'b1 : 1'($urandom);
            kn_in        <= (i == 1) ? 1'b1 : 1'($urandom);
            par          <= (i == 0) ? 4'ha : 4'($urandom);
            // long stalls every 50 cycles fill the buffer
            stall        <= (i % 50) >= 40;
            @(negedge clk_i);
            if (!clear_n_i) exp_q = 4'h0;
            chk("stages", {exp_q, ~exp_q[3]}, {q, q_inv});
            // an edge that still sees clear low keeps the stages cleared
            exp_q = clear_n_i ? next_q(exp_q, shift_load_i, j_in, kn_in, par)
                              : 4'h0;
            if (snap_valid === 1'b1)
                chk("snap_inv", {4'h0, ~snap[4]}, {4'h0, snap[0]});
            if (snap_stall === 1'b1) saw_stall = 1'b1;
        end
        chk("saw_stall", 5'h01, {4'h0, saw_stall});
        chk("taken", 5'h01, {4'h0, taken > 0});
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
